/* src/nbd_defs.svh */
// constants for the nibble bus device: codes, offsets, reset values, timing
`ifndef NBD_DEFS_SVH
`define NBD_DEFS_SVH

`define NBD_CMD_NOP 4'h0
`define NBD_CMD_ID 4'h1
`define NBD_CMD_PC_READ 4'h2
`define NBD_CMD_DP_READ 4'h3
`define NBD_CMD_PC_WRITE 4'h4
`define NBD_CMD_DP_WRITE 4'h5
`define NBD_CMD_LOAD_PC 4'h6
`define NBD_CMD_LOAD_DP 4'h7
`define NBD_CMD_CONFIG 4'h8
`define NBD_CMD_UNCONFIG 4'h9
`define NBD_CMD_POLL 4'ha
`define NBD_CMD_DEV_SPEC 4'hc
`define NBD_CMD_SHUTDOWN 4'he
`define NBD_CMD_RESET 4'hf

`define NBD_AUTO_SWITCH_BIT 2
`define NBD_LAST_NIBBLE 3'h4
`define NBD_ID_NIBBLES 3'h5

`define NBD_ID_TYPE_IO 4'hf
`define NBD_SIZE_CODE_MAX 4'hf
`define NBD_IO_BASE_BITS 5'h04
`define NBD_MEM_BASE_BITS 5'h0a
`define NBD_ADDR_BITS 5'h14

`define NBD_OFS_CTRL 8'h00
`define NBD_OFS_ID 8'h04
`define NBD_OFS_HARD_ADDR 8'h08
`define NBD_OFS_STATUS 8'h0c
`define NBD_OFS_PC 8'h10
`define NBD_OFS_DP 8'h14
`define NBD_OFS_CFG 8'h18
`define NBD_OFS_MEM_LO 8'h40
`define NBD_OFS_MEM_HI 8'h7c

`define NBD_CTRL_HARD 0
`define NBD_CTRL_SERVICE 1
`define NBD_STAT_CONFIGURED 0
`define NBD_STAT_SHUTDOWN 1
`define NBD_STAT_DEV_CMD 2

`define NBD_CTRL_RESET 2'h0
`define NBD_ID_RESET 20'h41f0f
`define NBD_HARD_ADDR_RESET 20'h00000
`define NBD_POLL_LINE 2'h0

`define NBD_CLK_NS 25
`define NBD_WAKE_NS 1000
`define NBD_WAKE_CYCLES (`NBD_WAKE_NS / `NBD_CLK_NS)

`endif

/* src/nbd_pkg.sv */
// types shared by the nibble bus device
package nbd_pkg;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } nbd_ahb_phase_t;

  typedef struct packed {
    logic strobe_n;
    logic cd_n;
    logic chain;
    logic [3:0] data;
  } nbd_link_t;

endpackage : nbd_pkg

/* src/nbd_device.sv */
// nibble bus peripheral with an ahb-lite register port
`timescale 1ns/1ps

`include "nbd_defs.svh"

module nbd_device (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bus_strobe_n,
  input wire logic command_data_select_n,
  output logic command_data_select_out,
  output logic command_data_select_oe,
  input wire logic [3:0] bus_data_in,
  output logic [3:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic chain_in,
  output logic chain_out
);

  localparam int WAKE_CYCLES = `NBD_WAKE_CYCLES;

  // space size in low address bits from the id code
  function automatic logic [4:0] space_bits(input logic [19:0] id);
    logic [4:0] base;
    logic [4:0] sum;
    base = (id[11:8] == `NBD_ID_TYPE_IO) ? `NBD_IO_BASE_BITS : `NBD_MEM_BASE_BITS;
    sum = base + {1'b0, `NBD_SIZE_CODE_MAX - id[3:0]};
    space_bits = (sum > `NBD_ADDR_BITS) ? `NBD_ADDR_BITS : sum;
  endfunction : space_bits

  // upper-bit compare of an address against the configuration
  function automatic logic addr_match(input logic [19:0] addr, input logic [19:0] cfg, input logic [19:0] id);
    logic [19:0] mask;
    mask = 20'hfffff << space_bits(id);
    addr_match = ((addr ^ cfg) & mask) == 20'h00000;
  endfunction : addr_match

  // link synchronisers
  nbd_pkg::nbd_link_t link_meta;
  nbd_pkg::nbd_link_t link_sync;
  nbd_pkg::nbd_link_t link_prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_meta <= '{strobe_n: 1'b1, cd_n: 1'b1, chain: 1'b0, data: 4'h0};
      link_sync <= '{strobe_n: 1'b1, cd_n: 1'b1, chain: 1'b0, data: 4'h0};
      link_prev <= '{strobe_n: 1'b1, cd_n: 1'b1, chain: 1'b0, data: 4'h0};
    end else begin
      link_meta <= '{strobe_n: bus_strobe_n, cd_n: command_data_select_n, chain: chain_in, data: bus_data_in};
      link_sync <= link_meta;
      link_prev <= link_sync;
    end
  end

  logic strobe_rise;
  logic strobe_fall;
  assign strobe_rise = link_sync.strobe_n & ~link_prev.strobe_n;
  assign strobe_fall = ~link_sync.strobe_n & link_prev.strobe_n;

  // software registers
  logic [1:0] ctrl;
  logic [19:0] id_code;
  logic [19:0] hard_addr;
  logic dev_cmd_seen;
  logic [3:0] mem [16];

  // bus-facing state
  logic [3:0] cmd;
  logic [2:0] nib_cnt;
  logic dummy_pending;
  logic [19:0] local_program_counter;
  logic [19:0] local_data_pointer;
  logic [19:0] cfg_addr;
  logic soft_configured;
  logic cfg_pending;
  logic shutdown;

  logic hard_mode;
  logic configured;
  logic [19:0] active_cfg;
  logic [19:0] active_addr;
  logic active_match;
  logic dp_match;
  logic service_need;
  assign hard_mode = ctrl[`NBD_CTRL_HARD];
  assign service_need = ctrl[`NBD_CTRL_SERVICE];
  assign configured = hard_mode | soft_configured;
  assign active_cfg = hard_mode ? hard_addr : cfg_addr;
  assign active_addr = cmd[0] ? local_data_pointer : local_program_counter;
  assign active_match = configured & addr_match(active_addr, active_cfg, id_code);
  assign dp_match = configured & addr_match(local_data_pointer, active_cfg, id_code);

  logic chain_ok;
  assign chain_ok = ~configured & link_sync.chain;

  logic is_read;
  logic is_write;
  logic is_load;
  assign is_read = (cmd == `NBD_CMD_PC_READ) || (cmd == `NBD_CMD_DP_READ);
  assign is_write = (cmd == `NBD_CMD_PC_WRITE) || (cmd == `NBD_CMD_DP_WRITE);
  assign is_load = (cmd == `NBD_CMD_LOAD_PC) || (cmd == `NBD_CMD_LOAD_DP);

  logic cmd_strobe;
  logic data_strobe;
  assign cmd_strobe = strobe_rise & ~link_sync.cd_n;
  assign data_strobe = strobe_rise & link_sync.cd_n;

  // command latch and nibble sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= `NBD_CMD_NOP;
      nib_cnt <= 3'h0;
      dummy_pending <= 1'b0;
    end else if (cmd_strobe) begin
      cmd <= link_sync.data;
      nib_cnt <= 3'h0;
      dummy_pending <= (link_sync.data == `NBD_CMD_PC_READ) || (link_sync.data == `NBD_CMD_DP_READ);
    end else if (data_strobe) begin
      if (is_read && dummy_pending) begin
        dummy_pending <= 1'b0;
      end else if (is_load) begin
        nib_cnt <= nib_cnt + 3'h1;
        if (nib_cnt == `NBD_LAST_NIBBLE) begin
          cmd[`NBD_AUTO_SWITCH_BIT] <= 1'b0;
          dummy_pending <= 1'b1;
          nib_cnt <= 3'h0;
        end
      end else if (nib_cnt < `NBD_ID_NIBBLES) begin
        nib_cnt <= nib_cnt + 3'h1;
      end
    end
  end

  // local address registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_program_counter <= 20'h00000;
      local_data_pointer <= 20'h00000;
    end else if (data_strobe) begin
      if (is_load && nib_cnt <= `NBD_LAST_NIBBLE) begin
        if (cmd[0]) begin
          local_data_pointer[nib_cnt*4 +: 4] <= link_sync.data;
        end else begin
          local_program_counter[nib_cnt*4 +: 4] <= link_sync.data;
        end
      end else if ((is_read && !dummy_pending) || is_write) begin
        if (cmd[0]) begin
          local_data_pointer <= local_data_pointer + 20'h00001;
        end else begin
          local_program_counter <= local_program_counter + 20'h00001;
        end
      end
    end
  end

  // configuration state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_configured <= 1'b0;
      cfg_pending <= 1'b0;
      cfg_addr <= 20'h00000;
    end else if (cmd_strobe) begin
      if (link_sync.data == `NBD_CMD_RESET) begin
        soft_configured <= 1'b0;
        cfg_pending <= 1'b0;
      end else if (link_sync.data == `NBD_CMD_UNCONFIG && !hard_mode && dp_match) begin
        soft_configured <= 1'b0;
        cfg_pending <= 1'b0;
      end else if (cfg_pending) begin
        soft_configured <= 1'b1;
        cfg_pending <= 1'b0;
      end
    end else if (data_strobe && cmd == `NBD_CMD_CONFIG && chain_ok && !hard_mode && !cfg_pending
                 && nib_cnt <= `NBD_LAST_NIBBLE) begin
      cfg_addr[nib_cnt*4 +: 4] <= link_sync.data;
      if (nib_cnt == `NBD_LAST_NIBBLE) begin
        cfg_pending <= 1'b1;
      end
    end
  end

  assign chain_out = configured & link_sync.chain;

  // shutdown tracking and device-specific command flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown <= 1'b0;
    end else if (cmd_strobe) begin
      shutdown <= (link_sync.data == `NBD_CMD_SHUTDOWN);
    end else if (strobe_fall) begin
      shutdown <= 1'b0;
    end
  end

  logic dev_cmd_hit;
  logic dev_cmd_clear;
  assign dev_cmd_hit = cmd_strobe && link_sync.data == `NBD_CMD_DEV_SPEC && dp_match;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_cmd_seen <= 1'b0;
    end else if (dev_cmd_hit) begin
      dev_cmd_seen <= 1'b1;
    end else if (dev_cmd_clear) begin
      dev_cmd_seen <= 1'b0;
    end
  end

  // wake request: one pulse per new service need
  logic woke;
  logic [5:0] wake_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      woke <= 1'b0;
      wake_cnt <= 6'h00;
    end else begin
      if (!service_need) begin
        woke <= 1'b0;
      end else if (shutdown && !woke) begin
        woke <= 1'b1;
        wake_cnt <= 6'(WAKE_CYCLES);
      end
      // own pull shows on the select input, so only a strobe may cut the pulse
      if (wake_cnt != 6'h00 && !(shutdown && service_need && !woke)) begin
        wake_cnt <= shutdown ? wake_cnt - 6'h01 : 6'h00;
      end
    end
  end
  assign command_data_select_out = 1'b0;
  assign command_data_select_oe = (wake_cnt != 6'h00);

  // read-side drive, set at strobe fall, released at strobe rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_data_out <= 4'h0;
      bus_data_oe <= 1'b0;
    end else if (strobe_rise || link_sync.strobe_n) begin
      bus_data_oe <= 1'b0;
      bus_data_out <= 4'h0;
    end else if (strobe_fall && link_sync.cd_n) begin
      if (cmd == `NBD_CMD_ID && chain_ok && !hard_mode && nib_cnt < `NBD_ID_NIBBLES) begin
        bus_data_oe <= 1'b1;
        bus_data_out <= id_code[nib_cnt*4 +: 4];
      end else if (is_read && !dummy_pending && active_match) begin
        bus_data_oe <= 1'b1;
        bus_data_out <= mem[active_addr[3:0]];
      end else if (cmd == `NBD_CMD_POLL && service_need && nib_cnt == 3'h0) begin
        bus_data_oe <= 1'b1;
        bus_data_out <= 4'h1 << `NBD_POLL_LINE;
      end
    end
  end

  // ahb-lite slave, zero wait states
  nbd_pkg::nbd_ahb_phase_t dphase;
  logic dphase_valid;
  logic addr_take;
  assign addr_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase <= '{write: 1'b0, addr: 8'h00};
      dphase_valid <= 1'b0;
    end else begin
      dphase_valid <= addr_take;
      if (addr_take) begin
        dphase <= '{write: hwrite, addr: haddr[7:0]};
      end
    end
  end

  logic sw_wr;
  logic mem_win_wr;
  assign sw_wr = dphase_valid & dphase.write;
  assign mem_win_wr = sw_wr && dphase.addr >= `NBD_OFS_MEM_LO && dphase.addr <= `NBD_OFS_MEM_HI;
  assign dev_cmd_clear = sw_wr && dphase.addr == `NBD_OFS_STATUS && hwdata[`NBD_STAT_DEV_CMD];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `NBD_CTRL_RESET;
      id_code <= `NBD_ID_RESET;
      hard_addr <= `NBD_HARD_ADDR_RESET;
    end else if (sw_wr) begin
      case (dphase.addr)
        `NBD_OFS_CTRL: ctrl <= hwdata[1:0];
        `NBD_OFS_ID: id_code <= hwdata[19:0];
        `NBD_OFS_HARD_ADDR: hard_addr <= hwdata[19:0];
        default: ;
      endcase
    end
  end

  // nibble storage; a bus write beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 4'h0;
      end
    end else if (data_strobe && is_write && active_match) begin
      mem[active_addr[3:0]] <= link_sync.data;
    end else if (mem_win_wr) begin
      mem[dphase.addr[5:2]] <= hwdata[3:0];
    end
  end

  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h00000000;
    if (haddr[7:0] >= `NBD_OFS_MEM_LO && haddr[7:0] <= `NBD_OFS_MEM_HI) begin
      rd_value = {28'h0000000, mem[haddr[5:2]]};
    end else begin
      case (haddr[7:0])
        `NBD_OFS_CTRL: rd_value = {30'h0000000, ctrl};
        `NBD_OFS_ID: rd_value = {12'h000, id_code};
        `NBD_OFS_HARD_ADDR: rd_value = {12'h000, hard_addr};
        `NBD_OFS_STATUS: rd_value = {24'h000000, cmd, 1'b0, dev_cmd_seen, shutdown, configured};
        `NBD_OFS_PC: rd_value = {12'h000, local_program_counter};
        `NBD_OFS_DP: rd_value = {12'h000, local_data_pointer};
        `NBD_OFS_CFG: rd_value = {12'h000, active_cfg};
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      hrdata <= rd_value;
    end
  end

endmodule : nbd_device

/* sim/nbd_device_props.sv */
// port checker for the nibble bus device
`timescale 1ns/1ps

module nbd_device_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic bus_strobe_n,
  input wire logic bus_data_oe,
  input wire logic command_data_select_out,
  input wire logic command_data_select_oe,
  input wire logic chain_in,
  input wire logic chain_out
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int wake_len;
  // length of the current wake pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_len <= 0;
    end else begin
      wake_len <= command_data_select_oe ? wake_len + 1 : 0;
    end
  end
  sequence s_rise;
    $rose(bus_strobe_n);
  endsequence
  sequence s_fall;
    $fell(bus_strobe_n);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
    else $error("read data moved");
  chk_drive_low: assert property ($rose(bus_data_oe) |-> !$past(bus_strobe_n, 2))
    else $error("drive without strobe low");
  chk_drive_end: assert property (s_rise |-> ##[1:5] !bus_data_oe)
    else $error("drive kept after strobe");
  chk_wake_len: assert property (wake_len <= 40)
    else $error("wake pulse too long");
  chk_wake_stop: assert property (s_fall |-> ##[1:5] !command_data_select_oe)
    else $error("wake kept while strobing");
  chk_wake_low: assert property (command_data_select_oe |-> !command_data_select_out)
    else $error("wake not driven low");
  chk_chain_drop: assert property ($fell(chain_in) |-> ##[1:4] !chain_out)
    else $error("chain out kept high");
  chk_chain_rise: assert property ($rose(chain_out) |-> chain_in && $past(chain_in))
    else $error("chain out rose without input");
endmodule : nbd_device_props

bind nbd_device nbd_device_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .bus_strobe_n(bus_strobe_n), .bus_data_oe(bus_data_oe), .command_data_select_out(command_data_select_out),
  .command_data_select_oe(command_data_select_oe), .chain_in(chain_in), .chain_out(chain_out));

/* sim/nbd_master_model.sv */
// bus master partner: strobe, select and precharged data lines
`timescale 1ns/1ps

module nbd_master_model (
  output logic strobe_n,
  output logic cd_n,
  output logic [3:0] data,
  output logic data_oe,
  input wire logic [3:0] wire_data
);
  initial begin
    strobe_n = 1'b1;
    cd_n = 1'b1;
    data = 4'h0;
    data_oe = 1'b0;
  end
  // one 200 ns strobe; stands still between calls
  task automatic stb(input logic cmd, input logic drv, input logic [3:0] nib, output logic [3:0] got);
    cd_n = !cmd;
    data = nib;
    data_oe = drv;
    #10 strobe_n = 1'b0;
    #95 got = wire_data;
    #5 strobe_n = 1'b1;
    #90 cd_n = 1'b1;
    data_oe = 1'b0;
    data = ~nib;
  endtask : stb
endmodule : nbd_master_model

/* sim/tb_top.sv */
// self-checking bench for the nibble bus device
`timescale 1ns/1ps
`include "nbd_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module tb_top;
  localparam logic [19:0] id_code = `NBD_ID_RESET;
  logic hclk, hresetn, hsel, hwrite, chain_in, hreadyout, hresp, chain_out;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, got_v, exp_v;
  logic m_str, m_cd, m_oe, d_oe, cd_out, cd_oe;
  logic [3:0] m_data, d_out;
  logic [31:0] act_q[$], exp_q[$];
  int fails = 0;
  int checks_done = 0;
  int wakes = 0;
  int wake_hi = 0;
  // data lines precharged low when nobody drives
  wire [3:0] bus_w = d_oe ? d_out : (m_oe ? m_data : 4'h0);
  wire cd_w = cd_oe ? cd_out : m_cd;

  nbd_master_model u_master (.strobe_n(m_str), .cd_n(m_cd), .data(m_data), .data_oe(m_oe), .wire_data(bus_w));
  nbd_device DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .bus_strobe_n(m_str), .command_data_select_n(cd_w),
    .command_data_select_out(cd_out), .command_data_select_oe(cd_oe), .bus_data_in(bus_w),
    .bus_data_out(d_out), .bus_data_oe(d_oe), .chain_in(chain_in), .chain_out(chain_out));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) begin
      exp_q.push_back(e);
      act_q.push_back(hrdata);
    end
  endtask : ahb

  task automatic cmd(input logic [3:0] c);
    logic [3:0] g;
    u_master.stb(1'b1, 1'b1, c, g);
  endtask : cmd

  task automatic wr(input logic [3:0] n);
    logic [3:0] g;
    u_master.stb(1'b0, 1'b1, n, g);
  endtask : wr

  task automatic rd(input logic [3:0] e);
    logic [3:0] g;
    exp_q.push_back({28'h0, e});
    u_master.stb(1'b0, 1'b0, 4'h0, g);
    act_q.push_back({28'h0, g});
  endtask : rd

  task automatic addr(input logic [19:0] a);
    for (int i = 0; i < 5; i++) wr(a[4 * i +: 4]);
  endtask : addr

  // oldest note against each result
  initial forever begin
    wait (act_q.size() != 0);
    got_v = act_q.pop_front();
    exp_v = exp_q.pop_front();
    `CHK(got_v, exp_v)
  end

  always @(posedge cd_oe) wakes++;
  // clock cycles with the wake pull standing
  always @(posedge hclk) if (cd_oe === 1'b1) wake_hi <= wake_hi + 1;

  initial begin
    #300000;
    fails++;
    end_sim();
  end

  initial begin
    logic [19:0] base;
    logic [3:0] wd [16];
    int n;
    {hsel, htrans, hwrite, haddr, hwdata} = '0;
    hresetn = 1'b0;
    chain_in = 1'b1;
    void'($urandom(76460));
    base = {16'($urandom()), 4'h0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(chain_out, 1'b0)
    ahb(1'b0, 8'h04, 32'h0, {12'h0, id_code});
    ahb(1'b0, 8'h30, 32'h0, 32'h0);
    cmd(4'h1);
    for (int i = 0; i < 5; i++) rd(id_code[4 * i +: 4]);
    cmd(4'h8);
    addr(base);
    `CHK(chain_out, 1'b0)
    cmd(4'h0);
    `CHK(chain_out, 1'b1)
    cmd(4'h1);
    rd(4'h0);
    for (int p = 0; p < 2; p++) begin
      n = 1 + $urandom_range(7);
      for (int i = 0; i < n; i++) wd[i] = 4'($urandom());
      cmd(4'h6 + 4'(p));
      addr(base + 20'h2);
      rd(4'h0);
      cmd(4'h4 + 4'(p));
      for (int i = 0; i < n; i++) wr(wd[i]);
      cmd(4'h6 + 4'(p));
      addr(base + 20'h2);
      if (p == 0) cmd(4'h2);
      rd(4'h0);
      for (int i = 0; i < n; i++) rd(wd[i]);
    end
    cmd(4'hc);
    ahb(1'b0, 8'h0c, 32'h0, 32'hc5);
    cmd(4'h6);
    addr(base ^ 20'h10000);
    rd(4'h0);
    rd(4'h0);
    ahb(1'b1, 8'h00, 32'h2, 32'h0);
    cmd(4'ha);
    rd(4'h1);
    cmd(4'he);
    for (int i = 0; i < 30 && cd_oe !== 1'b1; i++) @(posedge hclk);
    `CHK(cd_oe, 1'b1)
    repeat (50) @(posedge hclk);
    cmd(4'he);
    repeat (60) @(posedge hclk);
    `CHK(wakes, 1)
    `CHK(wake_hi, `NBD_WAKE_CYCLES)
    @(posedge hclk);
    chain_in <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK(chain_out, 1'b0)
    chain_in <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK(chain_out, 1'b1)
    cmd(4'h7);
    addr(base);
    cmd(4'h9);
    cmd(4'h0);
    `CHK(chain_out, 1'b0)
    cmd(4'h8);
    addr(base);
    cmd(4'hf);
    `CHK(chain_out, 1'b0)
    cmd(4'h8);
    addr(base);
    cmd(4'h0);
    `CHK(chain_out, 1'b1)
    cmd(4'hf);
    `CHK(chain_out, 1'b0)
    ahb(1'b1, `NBD_OFS_CTRL, 32'h1, 32'h0);
    ahb(1'b0, `NBD_OFS_CFG, 32'h0, {12'h0, `NBD_HARD_ADDR_RESET});
    `CHK(chain_out, 1'b1)
    cmd(4'hf);
    `CHK(chain_out, 1'b1)
    cmd(4'h1);
    rd(4'h0);
    wait (act_q.size() == 0);
    #1;
    end_sim();
  end
endmodule : tb_top
